// File: test/core_register_model.sv
// register space of the usb function controller behind the port
`timescale 1ns/1ps
module core_register_model (
	input wire logic                    clk,
	input wire logic                    rst_n,
	input wire usb_port_pkg::core_req_t core_req,
	input wire logic                    core_valid,
	input wire logic [3:0]              lat,
	output logic                        core_ack,
	output logic [7:0]                  core_rdata
);
	import usb_port_pkg::*;
	logic [7:0] mem [256];
	logic [3:0] wait_r;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			core_ack <= 1'b0;
			wait_r <= 4'h0;
			core_rdata <= 8'h5a;
		end else begin
			// data outside the ack cycle never holds
			core_rdata <= ~core_rdata;
			core_ack <= 1'b0;
			if (core_valid && !core_ack) begin
				if (wait_r >= lat) begin
					core_ack <= 1'b1;
					wait_r <= 4'h0;
					// indexed by endpoint and address
					if (core_req.write) mem[{core_req.endpoint, core_req.addr}] <= core_req.wdata;
					else core_rdata <= mem[{core_req.endpoint, core_req.addr}];
				end else begin
					wait_r <= wait_r + 4'h1;
				end
			end
		end
	end
endmodule : core_register_model

// File: test/usb_indirect_register_port_tb.sv
// self-checking bench for the indirect register port
`timescale 1ns/1ps
module usb_indirect_register_port_tb;
	import usb_port_pkg::*;
	typedef struct packed {
		logic [7:0] ep;
		logic [5:0] a;
		logic [7:0] d;
	} row_t;
	logic       clk, rst_n, core_ack, core_valid, frame_marker, osc_tick, recovery_active;
	logic [7:0] sfr_rdata, core_rdata, osc_trim, rv;
	logic [3:0] lat;
	sfr_bus_t   sfr;
	core_req_t  core_req, seen_r;
	int         mismatches, cmp_count;
	row_t       rows [16] = '{'{8'h0, 6'h02, 8'ha1}, '{8'h0, 6'h04, 8'hb2}, '{8'h0, 6'h06, 8'hc3},
		'{8'h0, 6'h07, 8'hd4}, '{8'h0, 6'h09, 8'he5}, '{8'h0, 6'h0b, 8'hf6}, '{8'h0, 6'h0c, 8'h17},
		'{8'h0, 6'h0d, 8'h28}, '{8'h1, 6'h11, 8'h39}, '{8'h2, 6'h12, 8'h4a}, '{8'h3, 6'h14, 8'h5b},
		'{8'h1, 6'h15, 8'h6c}, '{8'h2, 6'h16, 8'h7d}, '{8'h3, 6'h17, 8'h8e}, '{8'h0, 6'h20, 8'h9f},
		'{8'h3, 6'h23, 8'ha0}};
	usb_indirect_register_port #(.TICKS_FS(16'd8), .TICKS_LS(16'd4)) usb_indirect_register_port_inst (
		.clk(clk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata), .core_req(core_req),
		.core_valid(core_valid), .core_ack(core_ack), .core_rdata(core_rdata), .frame_marker(frame_marker),
		.osc_tick(osc_tick), .osc_trim(osc_trim), .recovery_active(recovery_active));
	core_register_model core_register_model_inst (.clk(clk), .rst_n(rst_n), .core_req(core_req),
		.core_valid(core_valid), .lat(lat), .core_ack(core_ack), .core_rdata(core_rdata));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) if (core_valid) seen_r <= core_req;
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		sfr = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		#1;
		sfr = '0;
		rv = sfr_rdata;
	endtask : bus
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(rv, e);
	endtask : rchk
	task automatic idle;
		for (int i = 0; i < 64; i++) begin
			bus(1'b0, 8'h96, 8'h00);
			if (rv[7] === 1'b0) return;
		end
		mismatches++;
		conclude();
	endtask : idle
	task automatic cwr(input logic [5:0] a, input logic [7:0] d);
		idle();
		bus(1'b1, 8'h96, {2'b00, a});
		bus(1'b1, 8'h97, d);
	endtask : cwr
	task automatic crd(input logic [5:0] a, input logic [7:0] e);
		idle();
		bus(1'b1, 8'h96, {2'b10, a});
		idle();
		rchk(8'h97, e);
	endtask : crd
	task automatic frames(input int first, input int last);
		for (int i = first; i < last; i++) begin
			frame_marker = i[2];
			osc_tick = i[0];
			@(posedge clk);
			#1;
		end
		osc_tick = 1'b0;
	endtask : frames
	initial begin
		sfr = '0;
		rst_n = 1'b0;
		frame_marker = 1'b0;
		osc_tick = 1'b0;
		lat = 4'h0;
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		rchk(8'h96, 8'h00);
		rchk(8'h97, 8'h00);
		rchk(8'h55, 8'h00);
		crd(6'h0e, 8'h00);
		crd(6'h0f, 8'h0f);
		$display("reset test done");
		foreach (rows[i]) begin
			lat = 4'(i % 4);
			cwr(6'h0e, rows[i].ep);
			cwr(rows[i].a, rows[i].d);
			idle();
			check({seen_r.endpoint, seen_r.addr}, {rows[i].ep[1:0], rows[i].a});
			crd(rows[i].a, rows[i].d);
		end
		$display("table test done");
		cwr(6'h0e, 8'hf2);
		crd(6'h0e, 8'h02);
		cwr(6'h0e, 8'h05);
		crd(6'h11, 8'h00);
		cwr(6'h0e, 8'h01);
		crd(6'h11, 8'h39);
		$display("endpoint select test done");
		lat = 4'h6;
		cwr(6'h07, 8'h11);
		idle();
		bus(1'b1, 8'h97, 8'h33);
		bus(1'b1, 8'h97, 8'h44);
		rchk(8'h96, 8'h87);
		crd(6'h07, 8'h33);
		$display("busy write test done");
		idle();
		bus(1'b1, 8'h96, 8'he0);
		idle();
		rchk(8'h97, 8'h9f);
		rchk(8'h96, 8'he0);
		idle();
		rchk(8'h97, 8'h9f);
		idle();
		bus(1'b1, 8'h96, 8'h00);
		$display("auto read test done");
		cwr(6'h0f, 8'h8f);
		crd(6'h0f, 8'h8f);
		frames(0, 20);
		check({7'h00, recovery_active}, 8'h01);
		check(osc_trim, 8'h82);
		cwr(6'h0f, 8'hcf);
		crd(6'h0f, 8'hcf);
		frames(20, 28);
		check(osc_trim, 8'h83);
		cwr(6'h0f, 8'haf);
		crd(6'h0f, 8'haf);
		frames(28, 36);
		check(osc_trim, 8'h84);
		$display("recovery test done");
		conclude();
	end
endmodule : usb_indirect_register_port_tb

// File: test/usb_port_properties.sv
// assertions on the indirect register port
`timescale 1ns/1ps
module usb_port_properties #(
	parameter logic [15:0] TICKS_FS = 16'd750,
	parameter logic [15:0] TICKS_LS = 16'd94
) (
	input wire logic                    clk,
	input wire logic                    rst_n,
	input wire usb_port_pkg::sfr_bus_t  sfr,
	input wire logic [7:0]              sfr_rdata,
	input wire usb_port_pkg::core_req_t core_req,
	input wire logic                    core_valid,
	input wire logic                    core_ack
);
	import usb_port_pkg::*;
	logic [5:0] last_r;
	always_ff @(posedge clk) if (core_valid) last_r <= core_req.addr;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_valid_holds: assert property (core_valid && !core_ack |=> core_valid)
		else $error("request dropped before ack");
	chk_req_stable: assert property (core_valid && !core_ack |=> $stable(core_req))
		else $error("request changed while pending");
	chk_valid_drops: assert property (core_valid && core_ack |=> !core_valid)
		else $error("request held after ack");
	chk_fetch_cause: assert property ($rose(core_valid) |-> $past(sfr.wr || sfr.rd))
		else $error("request without sfr access");
	chk_write_data: assert property ($rose(core_valid) && $past(sfr.wr && sfr.addr == 8'h97)
		|-> core_req.write && core_req.wdata == $past(sfr.wdata)) else $error("bad write request");
	chk_start_addr: assert property ($rose(core_valid) && $past(sfr.wr && sfr.addr == 8'h96)
		|-> !core_req.write && core_req.addr == $past(sfr.wdata[5:0])) else $error("bad read start");
	chk_auto_same: assert property ($rose(core_valid) && $past(sfr.rd)
		|-> !core_req.write && core_req.addr == last_r) else $error("auto read moved address");
	chk_local_kept: assert property (core_valid |-> core_req.addr != 6'h0e && core_req.addr != 6'h0f)
		else $error("local register forwarded");
	chk_busy_shown: assert property (core_valid && !core_ack && sfr.rd && sfr.addr == 8'h96 |=> sfr_rdata[7])
		else $error("busy not shown");
	chk_unmapped_zero: assert property (sfr.rd && sfr.addr != 8'h96 && sfr.addr != 8'h97 |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	cover property ($rose(core_valid) && core_req.write);
	cover property ($rose(core_valid) && !core_req.write);
	cover property ($rose(core_valid) && $past(sfr.rd));
endmodule : usb_port_properties

bind usb_indirect_register_port usb_port_properties #(.TICKS_FS(TICKS_FS), .TICKS_LS(TICKS_LS)) chk_inst (
	.clk(clk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata), .core_req(core_req),
	.core_valid(core_valid), .core_ack(core_ack));

// File: verilog/usb_indirect_register_port.sv
// indirect address/data port into the usb function controller register space
// What this block does
// - busy flag bit 7 marks data invalid
// - auto-read restarts read on data port read
// - address port bits 5:0 pick core register
// - auto-read leaves target address unchanged
// - address survives data port writes
// - address and busy set in one write
// - interrupt flags at 0x02, 0x04, 0x06
// - interrupt enables at 0x07, 0x09, 0x0b
// - frame number at 0x0c and 0x0d
// - endpoint0 csr 0x11, count 0x16, indexed
// - in csr high at 0x12, indexed
// - out csr at 0x14 and 0x15, indexed
// - out packet count high at 0x17, indexed
// - endpoint select codes 0..3, others reserved
// - endpoint select bits 7:4 read zero
// - recovery trims oscillator from bus timing
// - single-step calibration mode offered
// - 0x20-0x23 reach endpoint fifos
// - recovery enable bit at 0x0f
`timescale 1ns/1ps
`include "usb_port_defines.svh"

module usb_indirect_register_port #(
	parameter logic [15:0] TICKS_FS = `TICKS_FULL_SPEED,
	parameter logic [15:0] TICKS_LS = `TICKS_LOW_SPEED
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire usb_port_pkg::sfr_bus_t sfr,
	output logic [7:0]                  sfr_rdata,
	output usb_port_pkg::core_req_t     core_req,
	output logic                        core_valid,
	input  wire logic                   core_ack,
	input  wire logic [7:0]             core_rdata,
	input  wire logic                   frame_marker,
	input  wire logic                   osc_tick,
	output logic [7:0]                  osc_trim,
	output logic                        recovery_active
);
	import usb_port_pkg::*;

	// core address classes
	function automatic logic is_indexed(input logic [5:0] a);
		case (a)
			`CORE_EP0_CSR:        is_indexed = 1'b1;
			`CORE_EP0_COUNT:      is_indexed = 1'b1;
			`CORE_IN_CSR_HIGH:    is_indexed = 1'b1;
			`CORE_OUT_CSR_LOW:    is_indexed = 1'b1;
			`CORE_OUT_CSR_HIGH:   is_indexed = 1'b1;
			`CORE_OUT_COUNT_HIGH: is_indexed = 1'b1;
			default:              is_indexed = 1'b0;
		endcase
	endfunction : is_indexed

	function automatic logic is_local(input logic [5:0] a);
		case (a)
			`CORE_ENDPOINT_SELECT: is_local = 1'b1;
			`CORE_CLOCK_RECOVERY:  is_local = 1'b1;
			default:               is_local = 1'b0;
		endcase
	endfunction : is_local

	function automatic logic is_fifo(input logic [5:0] a);
		is_fifo = (a >= `CORE_FIFO_FIRST) && (a <= `CORE_FIFO_LAST);
	endfunction : is_fifo

	// endpoint sent with a core access: index for indexed registers, low bits for fifos
	function automatic logic [1:0] route_endpoint(input logic [5:0] a, input logic [3:0] sel);
		case (a)
			`CORE_IN_FLAGS:       route_endpoint = 2'b00;
			`CORE_OUT_FLAGS:      route_endpoint = 2'b00;
			`CORE_COMMON_FLAGS:   route_endpoint = 2'b00;
			`CORE_IN_ENABLES:     route_endpoint = 2'b00;
			`CORE_OUT_ENABLES:    route_endpoint = 2'b00;
			`CORE_COMMON_ENABLES: route_endpoint = 2'b00;
			`CORE_FRAME_LOW:      route_endpoint = 2'b00;
			`CORE_FRAME_HIGH:     route_endpoint = 2'b00;
			default: begin
				if (is_indexed(a))
					route_endpoint = sel[1:0];
				else if (is_fifo(a))
					route_endpoint = a[1:0];
				else
					route_endpoint = 2'b00;
			end
		endcase
	endfunction : route_endpoint

	// registers kept in this block; reserved endpoint reads zero
	function automatic logic [7:0] local_read(input logic [5:0] a, input logic [3:0] sel, input logic [7:0] rec);
		case (a)
			`CORE_ENDPOINT_SELECT: local_read = {4'h0, sel};
			`CORE_CLOCK_RECOVERY:  local_read = rec;
			default:               local_read = 8'h00;
		endcase
	endfunction : local_read

	// sfr view of the two ports; other addresses read zero
	function automatic logic [7:0] port_read(input logic [7:0] a, input logic [7:0] view, input logic [7:0] dat);
		case (a)
			`SFR_ADDRESS_PORT: port_read = view;
			`SFR_DATA_PORT:    port_read = dat;
			default:           port_read = 8'h00;
		endcase
	endfunction : port_read

	// correction step: single step, else error over four clamped to 1..16
	function automatic logic [7:0] trim_step(input logic [15:0] err, input logic single);
		if (single || ((err >> `TRIM_SHIFT) == 16'h0000))
			trim_step = 8'h01;
		else if ((err >> `TRIM_SHIFT) > 16'h000f)
			trim_step = 8'h10;
		else
			trim_step = 8'(err >> `TRIM_SHIFT);
	endfunction : trim_step

	port_state_t state_r;
	port_state_t state_nxt;
	logic [5:0]  target_r;
	logic        auto_read_r;
	logic [7:0]  data_r;
	logic [3:0]  ep_select_r;
	logic [7:0]  recovery_r;
	logic [7:0]  rdata_r;
	core_req_t   req_r;
	logic        valid_r;
	logic [7:0]  local_rdata;

	// sfr decode
	wire addr_wr = sfr.wr && (sfr.addr == `SFR_ADDRESS_PORT);
	wire data_wr = sfr.wr && (sfr.addr == `SFR_DATA_PORT);
	wire data_rd = sfr.rd && (sfr.addr == `SFR_DATA_PORT);
	wire idle    = (state_r == ST_IDLE);
	wire busy    = !idle;

	// a manual start, or an auto restart on data port read
	wire start_manual = addr_wr && sfr.wdata[`BUSY_BIT] && idle;
	wire start_auto   = data_rd && auto_read_r && idle;
	wire start_read   = start_manual || start_auto;
	wire start_write  = data_wr && idle;

	// manual start uses the address written in the same access
	wire [5:0] next_target = addr_wr ? sfr.wdata[`ADDR_MSB:0] : target_r;
	wire [5:0] op_target   = start_manual ? sfr.wdata[`ADDR_MSB:0] : target_r;

	// reserved endpoint codes reach no endpoint
	wire ep_valid   = ep_select_r <= `EP_LAST;
	wire blocked    = is_indexed(op_target) && !ep_valid;
	wire op_local   = is_local(op_target) || blocked;
	wire cur_local  = is_local(req_r.addr)
		|| (is_indexed(req_r.addr) && !ep_valid);

	// local register read values
	assign local_rdata = local_read(req_r.addr, ep_select_r, recovery_r);

	wire done = !idle && (cur_local || core_ack);

	// one fetch or store in flight at a time
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_write)
					state_nxt = ST_WRITE;
				else if (start_read)
					state_nxt = ST_READ;
			end
			ST_READ: begin
				if (done)
					state_nxt = ST_IDLE;
			end
			ST_WRITE: begin
				if (done)
					state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// address port fields
	// target address, kept across data port accesses
	always_ff @(posedge clk) begin
		if (!rst_n)
			target_r <= 6'(`ADDRESS_PORT_RESET);
		else if (addr_wr)
			target_r <= next_target;
	end

	// auto-read flag
	always_ff @(posedge clk) begin
		if (!rst_n)
			auto_read_r <= 1'b0;
		else if (addr_wr)
			auto_read_r <= sfr.wdata[`AUTO_READ_BIT];
	end

	// core request, held until acknowledged
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req_r <= '0;
		end else if (start_write || start_read) begin
			req_r.write    <= start_write;
			req_r.addr     <= op_target;
			req_r.endpoint <= route_endpoint(op_target, ep_select_r);
			req_r.wdata    <= sfr.wdata;
		end
	end

	// no core access for local registers or a reserved endpoint
	always_ff @(posedge clk) begin
		if (!rst_n)
			valid_r <= 1'b0;
		else if (start_write || start_read)
			valid_r <= !op_local;
		else if (core_ack)
			valid_r <= 1'b0;
	end

	// endpoint select and clock recovery control live in this block
	wire blocked_cur = is_indexed(req_r.addr) && !ep_valid;
	wire local_wr    = (state_r == ST_WRITE) && cur_local && !blocked_cur;

	always_ff @(posedge clk) begin
		if (!rst_n)
			ep_select_r <= `ENDPOINT_SELECT_RESET;
		else if (local_wr && (req_r.addr == `CORE_ENDPOINT_SELECT))
			ep_select_r <= req_r.wdata[`EPSEL_MSB:0];
	end

	// clock recovery control, stored whole
	always_ff @(posedge clk) begin
		if (!rst_n)
			recovery_r <= `CLOCK_RECOVERY_RESET;
		else if (local_wr && (req_r.addr == `CORE_CLOCK_RECOVERY))
			recovery_r <= req_r.wdata;
	end

	// fetched data, valid once busy falls
	always_ff @(posedge clk) begin
		if (!rst_n)
			data_r <= `DATA_PORT_RESET;
		else if ((state_r == ST_READ) && done)
			data_r <= cur_local ? local_rdata : core_rdata;
	end

	// registered read mux of the two sfr ports
	wire [7:0] addr_view = {busy, auto_read_r, target_r};
	wire [7:0] rd_mux    = port_read(sfr.addr, addr_view, data_r);

	always_ff @(posedge clk) begin
		if (!rst_n)
			rdata_r <= 8'h00;
		else if (sfr.rd)
			rdata_r <= rd_mux;
	end

	assign sfr_rdata  = rdata_r;
	assign core_req   = req_r;
	assign core_valid = valid_r;

	// clock recovery: pins pass three flops
	logic [2:0] frame_s_r;
	logic [2:0] tick_s_r;
	logic       frame_lvl_r;
	logic       tick_lvl_r;

	always_ff @(posedge clk) begin
		if (!rst_n)
			frame_s_r <= 3'h0;
		else
			frame_s_r <= {frame_s_r[1:0], frame_marker};
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			tick_s_r <= 3'h0;
		else
			tick_s_r <= {tick_s_r[1:0], osc_tick};
	end

	// a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n)
			frame_lvl_r <= 1'b0;
		else if (frame_s_r[1] == frame_s_r[2])
			frame_lvl_r <= frame_s_r[2];
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			tick_lvl_r <= 1'b0;
		else if (tick_s_r[1] == tick_s_r[2])
			tick_lvl_r <= tick_s_r[2];
	end

	wire frame_rise = frame_s_r[1] && frame_s_r[2] && !frame_lvl_r;
	wire tick_rise  = tick_s_r[1] && tick_s_r[2] && !tick_lvl_r;

	wire recovery_on = recovery_r[`RECOVERY_ENABLE_BIT];
	wire single_step = recovery_r[`SINGLE_STEP_BIT];
	wire low_speed   = recovery_r[`LOW_SPEED_BIT];
	wire [15:0] nominal = low_speed ? TICKS_LS : TICKS_FS;

	logic [15:0] tick_count_r;
	logic        armed_r;
	logic [7:0]  trim_r;
	logic        active_r;

	// oscillator ticks counted over one bus frame
	always_ff @(posedge clk) begin
		if (!rst_n || !recovery_on)
			tick_count_r <= 16'h0000;
		else if (frame_rise)
			tick_count_r <= 16'h0000;
		else if (tick_rise && (tick_count_r != 16'hffff))
			tick_count_r <= tick_count_r + 16'h0001;
	end

	// signed error of the last frame, step size by mode
	wire        too_fast = tick_count_r > nominal;
	wire        too_slow = tick_count_r < nominal;
	wire [15:0] err_mag  = too_fast ? tick_count_r - nominal : nominal - tick_count_r;
	wire [7:0]  step     = trim_step(err_mag, single_step);
	wire [8:0]  trim_up  = {1'b0, trim_r} + {1'b0, step};
	wire [8:0]  trim_dn  = {1'b0, trim_r} - {1'b0, step};

	// first frame after enabling only arms
	always_ff @(posedge clk) begin
		if (!rst_n || !recovery_on)
			armed_r <= 1'b0;
		else if (frame_rise)
			armed_r <= 1'b1;
	end

	// reported once a frame has been seen
	always_ff @(posedge clk) begin
		if (!rst_n || !recovery_on)
			active_r <= 1'b0;
		else if (frame_rise)
			active_r <= 1'b1;
	end

	// later frames adjust the trim, saturating
	always_ff @(posedge clk) begin
		if (!rst_n)
			trim_r <= `TRIM_RESET;
		else if (recovery_on && frame_rise && armed_r && too_fast)
			trim_r <= trim_dn[8] ? 8'h00 : trim_dn[7:0];
		else if (recovery_on && frame_rise && armed_r && too_slow)
			trim_r <= trim_up[8] ? 8'hff : trim_up[7:0];
	end

	assign osc_trim        = trim_r;
	assign recovery_active = active_r;

endmodule : usb_indirect_register_port

// File: verilog/usb_port_defines.svh
// offsets, field positions, reset values and timing counts of the indirect port
`ifndef USB_PORT_DEFINES_SVH
`define USB_PORT_DEFINES_SVH
`define SFR_ADDRESS_PORT     8'h96
`define SFR_DATA_PORT        8'h97
`define CORE_IN_FLAGS        6'h02
`define CORE_OUT_FLAGS       6'h04
`define CORE_COMMON_FLAGS    6'h06
`define CORE_IN_ENABLES      6'h07
`define CORE_OUT_ENABLES     6'h09
`define CORE_COMMON_ENABLES  6'h0b
`define CORE_FRAME_LOW       6'h0c
`define CORE_FRAME_HIGH      6'h0d
`define CORE_ENDPOINT_SELECT 6'h0e
`define CORE_CLOCK_RECOVERY  6'h0f
`define CORE_EP0_CSR         6'h11
`define CORE_IN_CSR_HIGH     6'h12
`define CORE_OUT_CSR_LOW     6'h14
`define CORE_OUT_CSR_HIGH    6'h15
`define CORE_EP0_COUNT       6'h16
`define CORE_OUT_COUNT_HIGH  6'h17
`define CORE_FIFO_FIRST      6'h20
`define CORE_FIFO_LAST       6'h23
`define BUSY_BIT             7
`define AUTO_READ_BIT        6
`define ADDR_MSB             5
`define EPSEL_MSB            3
`define EP_LAST              4'h3
`define RECOVERY_ENABLE_BIT  7
`define SINGLE_STEP_BIT      6
`define LOW_SPEED_BIT        5
`define ADDRESS_PORT_RESET   8'h00
`define DATA_PORT_RESET      8'h00
`define ENDPOINT_SELECT_RESET 4'h0
`define CLOCK_RECOVERY_RESET 8'h0f
`define TRIM_RESET           8'h80
`define TICKS_FULL_SPEED     16'd750
`define TICKS_LOW_SPEED      16'd94
`define TRIM_SHIFT           2
`endif

// File: verilog/usb_port_pkg.sv
// types shared by the indirect register port
package usb_port_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b100
	} port_state_t;

	typedef struct packed {
		logic       write;
		logic [5:0] addr;
		logic [1:0] endpoint;
		logic [7:0] wdata;
	} core_req_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_bus_t;
endpackage : usb_port_pkg
